// ---- rtl/lsife_pkg.sv ----
// Constants and types of the sample input front end
//
// Overview of operation
// - Samples reach the converter only while transmit_gate is high; while it is low the code is all zeros and the sample lanes are ignored.
// - A high sleep input puts the device into its low-power state; low means normal operation, and a pulldown holds it low.
// - The sample lanes are captured at double data rate, two words in every input_word_clock cycle.
// - Channel A words arrive on the rising and channel B words on the falling edge of input_word_clock and are split there.
// - Without bus reversal lane 13 is the most and lane 0 the least significant bit of each word.
// - fifo_restart_pair is sampled on the rising edge of input_word_clock and restarts the input FIFO.
// - divider_align_pair is sampled on the rising edge of conversion_clock and resets the dividers and FIFO output phase.
// - With divider_align_pair left unconnected (low) the device works normally without alignment.
// - Codes are offset binary: all zeros gives full-scale current and all ones gives zero current.
package lsife_pkg;

  localparam int LSIFE_LANES = 14;
  localparam int LSIFE_FIFO_DEPTH = 32;
  localparam int LSIFE_LEVEL_W = 6;
  localparam int LSIFE_DIV_W = 2;

  // Reset values and the last divider count
  localparam logic [LSIFE_LANES-1:0] LSIFE_CODE_RST = 14'h0000;
  localparam logic [LSIFE_LANES-1:0] LSIFE_ZERO_CURRENT = 14'h0000;
  localparam logic [LSIFE_DIV_W-1:0] LSIFE_DIV_RST = 2'h0;
  localparam logic [LSIFE_DIV_W-1:0] LSIFE_DIV_LAST = 2'h1;

  typedef logic [LSIFE_LANES-1:0] lsife_word_t;

  // Pin group after the two-flop synchroniser
  typedef struct packed {
    lsife_word_t lanes;
    logic word_clk;
    logic restart;
    logic conv_clk;
    logic align;
    logic gate;
    logic sleep;
    logic reverse;
  } lsife_pins_t;

  // Channel A and B words of one input clock cycle
  typedef struct packed {
    lsife_word_t chan_a;
    lsife_word_t chan_b;
  } lsife_pair_t;

  typedef enum logic [1:0] {
    LSIFE_WAIT,
    LSIFE_CHAN_A,
    LSIFE_CHAN_B
  } lsife_out_state_t;

endpackage

// ---- rtl/lsife_sync2.sv ----
// Two-flop synchroniser for pin inputs
module lsife_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_stage1 = async_i;
    next_sync = stage1;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= next_stage1;
      sync_o <= next_sync;
    end
  end

endmodule

// ---- rtl/lsife_fifo.sv ----
// Flip-flop FIFO with valid and ready on both sides
module lsife_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  always_comb begin
    in_ready_o = (count != (AW + 1)'(DEPTH)) | (out_ready_i & (count != '0));
    out_valid_o = (count != '0);
    out_data_o = mem[rd_ptr];
    level_o = count;
    push = in_valid_i & in_ready_o & ~flush_i;
    pop = out_valid_o & out_ready_i & ~flush_i;
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = (AW + 1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (AW + 1)'(count - 1'b1);
    end
    if (flush_i) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule

// ---- rtl/lsife_top.sv ----
// Sample input front end: DDR capture, FIFO and conversion-clock output
module lsife_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Sample link pins
  input wire logic [lsife_pkg::LSIFE_LANES-1:0] sample_lanes_i,
  input wire logic input_word_clock_i,
  input wire logic fifo_restart_pair_i,
  // Conversion clock pins
  input wire logic conversion_clock_i,
  input wire logic divider_align_pair_i,
  // Control pins
  input wire logic transmit_gate_i,
  input wire logic sleep_i,
  input wire logic bus_reverse_i,
  // Converter side
  output logic [lsife_pkg::LSIFE_LANES-1:0] conv_code_o,
  output logic [lsife_pkg::LSIFE_LANES-1:0] current_level_o,
  output logic conv_valid_o,
  output logic channel_b_o,
  output logic divider_tick_o,
  // Status
  output logic sleep_o,
  output logic fifo_empty_o,
  output logic [lsife_pkg::LSIFE_LEVEL_W-1:0] fifo_level_o,
  output logic overflow_o,
  output logic underflow_o
);
  import lsife_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  lsife_pins_t raw_pins;
  lsife_pins_t pins;

  assign raw_pins = '{
    lanes: sample_lanes_i,
    word_clk: input_word_clock_i,
    restart: fifo_restart_pair_i,
    conv_clk: conversion_clock_i,
    align: divider_align_pair_i,
    gate: transmit_gate_i,
    sleep: sleep_i,
    reverse: bus_reverse_i
  };

  lsife_sync2 #(
    .WIDTH($bits(lsife_pins_t))
  ) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(raw_pins),
    .sync_o(pins)
  );

  // Bit order of a lane word
  function automatic lsife_word_t lane_order(input lsife_word_t w, input logic rev);
    lsife_word_t r;
    r = w;
    if (rev) begin
      for (int i = 0; i < LSIFE_LANES; i++) begin
        r[i] = w[LSIFE_LANES-1-i];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Edge detection

  logic word_clk_prev;
  logic conv_clk_prev;
  logic next_word_clk_prev;
  logic next_conv_clk_prev;
  logic word_rise;
  logic word_fall;
  logic conv_rise;
  logic active;

  always_comb begin
    next_word_clk_prev = pins.word_clk;
    next_conv_clk_prev = pins.conv_clk;
    word_rise = pins.word_clk & ~word_clk_prev;
    word_fall = ~pins.word_clk & word_clk_prev;
    conv_rise = pins.conv_clk & ~conv_clk_prev;
    active = pins.gate & ~pins.sleep;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_clk_prev <= 1'b0;
      conv_clk_prev <= 1'b0;
    end else begin
      word_clk_prev <= next_word_clk_prev;
      conv_clk_prev <= next_conv_clk_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // DDR capture into the FIFO

  lsife_word_t hold_a;
  logic hold_a_valid;
  logic overflow;
  lsife_word_t next_hold_a;
  logic next_hold_a_valid;
  logic next_overflow;
  lsife_word_t lanes;
  logic fifo_flush;
  logic fifo_in_valid;
  logic fifo_in_ready;
  lsife_pair_t fifo_in_data;

  always_comb begin
    lanes = lane_order(pins.lanes, pins.reverse);
    fifo_flush = word_rise & pins.restart;
    next_hold_a = hold_a;
    next_hold_a_valid = hold_a_valid;
    fifo_in_valid = 1'b0;
    fifo_in_data = '{chan_a: hold_a, chan_b: lanes};
    next_overflow = 1'b0;
    if (!active || fifo_flush) begin
      next_hold_a_valid = 1'b0;
    end else if (word_rise) begin
      next_hold_a = lanes;
      next_hold_a_valid = 1'b1;
    end else if (word_fall && hold_a_valid) begin
      fifo_in_valid = 1'b1;
      next_overflow = ~fifo_in_ready;
      next_hold_a_valid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_a <= LSIFE_CODE_RST;
      hold_a_valid <= 1'b0;
      overflow <= 1'b0;
    end else begin
      hold_a <= next_hold_a;
      hold_a_valid <= next_hold_a_valid;
      overflow <= next_overflow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input FIFO

  logic fifo_out_valid;
  logic fifo_out_ready;
  lsife_pair_t fifo_out_data;
  logic [LSIFE_LEVEL_W-1:0] fifo_level;

  lsife_fifo #(
    .WIDTH($bits(lsife_pair_t)),
    .DEPTH(LSIFE_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .flush_i(fifo_flush),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data),
    .level_o(fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion-clock output sequencing and divider

  lsife_out_state_t state;
  lsife_out_state_t next_state;
  lsife_word_t chan_b_word;
  lsife_word_t next_chan_b_word;
  logic [LSIFE_DIV_W-1:0] div_count;
  logic [LSIFE_DIV_W-1:0] next_div_count;
  lsife_word_t code;
  lsife_word_t next_code;
  logic next_valid;
  logic next_chan_b;
  logic next_tick;
  logic next_underflow;
  logic align_hit;

  always_comb begin
    align_hit = conv_rise & pins.align;
    next_state = state;
    next_chan_b_word = chan_b_word;
    next_div_count = div_count;
    next_code = code;
    next_valid = conv_valid_o;
    next_chan_b = channel_b_o;
    next_tick = 1'b0;
    next_underflow = 1'b0;
    fifo_out_ready = 1'b0;
    if (conv_rise) begin
      next_div_count = (div_count == LSIFE_DIV_LAST) ? LSIFE_DIV_RST
                       : LSIFE_DIV_W'(div_count + 1'b1);
      next_tick = (div_count == LSIFE_DIV_LAST);
    end
    if (align_hit) begin
      // Aligning rise restarts the divider and gives no tick
      next_div_count = LSIFE_DIV_RST;
      next_tick = 1'b0;
      next_state = LSIFE_WAIT;
      next_code = LSIFE_CODE_RST;
      next_valid = 1'b0;
      next_chan_b = 1'b0;
    end else if (!active) begin
      next_state = LSIFE_WAIT;
      next_code = LSIFE_CODE_RST;
      next_valid = 1'b0;
      next_chan_b = 1'b0;
    end else if (conv_rise) begin
      case (state)
        LSIFE_CHAN_A: begin
          next_code = chan_b_word;
          next_chan_b = 1'b1;
          next_state = LSIFE_CHAN_B;
        end
        LSIFE_WAIT, LSIFE_CHAN_B: begin
          if (fifo_out_valid) begin
            fifo_out_ready = 1'b1;
            next_code = fifo_out_data.chan_a;
            next_chan_b_word = fifo_out_data.chan_b;
            next_valid = 1'b1;
            next_chan_b = 1'b0;
            next_state = LSIFE_CHAN_A;
          end else begin
            next_code = LSIFE_CODE_RST;
            next_valid = 1'b0;
            next_chan_b = 1'b0;
            next_underflow = (state == LSIFE_CHAN_B);
            next_state = LSIFE_WAIT;
          end
        end
        default: begin
          next_state = LSIFE_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= LSIFE_WAIT;
      chan_b_word <= LSIFE_CODE_RST;
      div_count <= LSIFE_DIV_RST;
      code <= LSIFE_CODE_RST;
      conv_valid_o <= 1'b0;
      channel_b_o <= 1'b0;
      divider_tick_o <= 1'b0;
      underflow_o <= 1'b0;
    end else begin
      state <= next_state;
      chan_b_word <= next_chan_b_word;
      div_count <= next_div_count;
      code <= next_code;
      conv_valid_o <= next_valid;
      channel_b_o <= next_chan_b;
      divider_tick_o <= next_tick;
      underflow_o <= next_underflow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Converter drive and status

  lsife_word_t next_current;
  logic next_sleep;
  logic next_empty;

  always_comb begin
    next_sleep = pins.sleep;
    next_current = pins.sleep ? LSIFE_ZERO_CURRENT : ~next_code;
    next_empty = ~fifo_out_valid;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_code_o <= LSIFE_CODE_RST;
      current_level_o <= LSIFE_ZERO_CURRENT;
      sleep_o <= 1'b0;
      fifo_empty_o <= 1'b1;
      fifo_level_o <= '0;
      overflow_o <= 1'b0;
    end else begin
      conv_code_o <= next_code;
      current_level_o <= next_current;
      sleep_o <= next_sleep;
      fifo_empty_o <= next_empty;
      fifo_level_o <= fifo_level;
      overflow_o <= overflow;
    end
  end

endmodule

// ---- test/lsife_assertions.sv ----
// Port assertions of the sample input front end
module lsife_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Pins
  input wire logic input_word_clock_i,
  input wire logic fifo_restart_pair_i,
  input wire logic conversion_clock_i,
  input wire logic divider_align_pair_i,
  input wire logic transmit_gate_i,
  input wire logic sleep_i,
  // Outputs
  input wire logic [13:0] conv_code_o,
  input wire logic [13:0] current_level_o,
  input wire logic channel_b_o,
  input wire logic divider_tick_o,
  input wire logic sleep_o,
  input wire logic [5:0] fifo_level_o,
  input wire logic overflow_o,
  input wire logic underflow_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence held(c);
    $rose(conversion_clock_i) && c ##1 c [*6];
  endsequence
  a_gate_zero: assert property (held(!transmit_gate_i) |-> conv_code_o == 14'h0000)
    else $error("code not zero with gate low");
  a_gate_drop: assert property (!transmit_gate_i [*8] |->
    fifo_level_o <= $past(fifo_level_o))
    else $error("fifo filled with gate low");
  a_sleep_off: assert property (held(sleep_i) |->
    sleep_o && current_level_o == 14'h0000)
    else $error("no sleep state");
  a_full_scale: assert property (held(!transmit_gate_i && !sleep_i) |->
    current_level_o == 14'h3fff)
    else $error("gate low not full scale");
  a_code_invert: assert property (held(!sleep_i) |->
    current_level_o == ~conv_code_o)
    else $error("current not inverse of code");
  a_flush_level: assert property ($rose(input_word_clock_i) && fifo_restart_pair_i
    ##1 fifo_restart_pair_i [*2] |-> ##[2:5] fifo_level_o == 6'h00)
    else $error("fifo not flushed");
  a_tick_pulse: assert property (divider_tick_o |=> !divider_tick_o)
    else $error("tick longer than one cycle");
  a_align_tick: assert property (divider_align_pair_i [*8] |-> !divider_tick_o)
    else $error("tick while aligning");
  cover property (overflow_o);
  cover property (underflow_o);
  cover property ($rose(channel_b_o));
endmodule

// ---- test/lsife_source.sv ----
// Data source model for the DDR sample link
module lsife_source (
  // Clock
  input wire logic clk_i,
  // Link pins
  output lsife_pkg::lsife_word_t lanes_o,
  output logic wclk_o,
  output logic restart_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import lsife_pkg::*;
  initial begin
    lanes_o = 14'h0000;
    wclk_o = 1'b0;
    restart_o = 1'b0;
  end
  // One word held three cycles each side of its clock edge
  task automatic put(input lsife_word_t d, input logic e, input logic r);
    @(posedge clk_i);
    #5;
    lanes_o = d;
    restart_o = r;
    repeat (3) @(posedge clk_i);
    #5;
    wclk_o = e;
    repeat (2) @(posedge clk_i);
  endtask
  // Channel A on the rising edge, channel B on the falling edge
  task automatic send(input lsife_word_t a, input lsife_word_t b, input logic r);
    put(a, 1'b1, r);
    put(b, 1'b0, 1'b0);
    @(posedge clk_i);
    #5;
    lanes_o = ~b;
  endtask
endmodule

// ---- test/tb_lsife_top.sv ----
// Self-checking bench of the sample input front end
module tb_lsife_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lsife_pkg::*;
  logic clk_i, nrst_i, cclk, align, gate, slp, rev;
  lsife_word_t lanes, code, cur;
  logic wclk, rst_p, valid, chb, tick, slp_o, empty, ovf, unf;
  logic [5:0] level;
  int num_errors = 0;
  int checked = 0;
  int ticks = 0;
  int ovfs = 0;
  int unfs = 0;
  lsife_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .sample_lanes_i(lanes),
    .input_word_clock_i(wclk), .fifo_restart_pair_i(rst_p), .conversion_clock_i(cclk),
    .divider_align_pair_i(align), .transmit_gate_i(gate), .sleep_i(slp),
    .bus_reverse_i(rev), .conv_code_o(code), .current_level_o(cur), .conv_valid_o(valid),
    .channel_b_o(chb), .divider_tick_o(tick), .sleep_o(slp_o), .fifo_empty_o(empty),
    .fifo_level_o(level), .overflow_o(ovf), .underflow_o(unf));
  lsife_source src_u (.clk_i(clk_i), .lanes_o(lanes), .wclk_o(wclk), .restart_o(rst_p));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    ticks += int'(tick === 1'b1);
    ovfs += int'(ovf === 1'b1);
    unfs += int'(unf === 1'b1);
  end
  task automatic chk(input lsife_word_t got, input lsife_word_t exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic sync();
    @(posedge clk_i);
    #5;
  endtask
  task automatic crise();
    sync();
    cclk = 1'b1;
    repeat (3) sync();
    cclk = 1'b0;
    repeat (3) sync();
  endtask
  task automatic wait_lvl(input logic [5:0] n);
    for (int i = 0; level !== n; i++) begin
      if (i == 60) begin
        num_errors++;
        $display("[ERR] %0t level timeout", $time);
        print_verdict();
      end
      sync();
    end
    chk({8'h00, level}, {8'h00, n});
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_pass();
    src_u.send(14'h2a5c, 14'h15a3, 1'b0);
    wait_lvl(6'h01);
    crise();
    chk(code, 14'h2a5c);
    chk({12'h000, valid, chb}, 14'h0002);
    chk(cur, 14'h15a3);
    crise();
    chk(code, 14'h15a3);
    chk({13'h0, chb}, 14'h0001);
    rev = 1'b1;
    src_u.send(14'h0001, 14'h2000, 1'b0);
    wait_lvl(6'h01);
    crise();
    chk(code, 14'h2000);
    crise();
    chk(code, 14'h0001);
    rev = 1'b0;
    $display("t_pass done");
  endtask
  task automatic t_gate();
    gate = 1'b0;
    src_u.send(14'h3fff, 14'h3fff, 1'b0);
    repeat (6) sync();
    chk({8'h00, level}, 14'h0000);
    crise();
    chk(code, 14'h0000);
    chk(cur, 14'h3fff);
    gate = 1'b1;
    $display("t_gate done");
  endtask
  task automatic t_sleep();
    slp = 1'b1;
    crise();
    repeat (2) sync();
    chk({13'h0, slp_o}, 14'h0001);
    chk(cur, 14'h0000);
    slp = 1'b0;
    repeat (6) sync();
    chk({13'h0, slp_o}, 14'h0000);
    $display("t_sleep done");
  endtask
  task automatic t_restart();
    src_u.send(14'h0011, 14'h0022, 1'b0);
    src_u.send(14'h0033, 14'h0044, 1'b0);
    wait_lvl(6'h02);
    src_u.send(14'h0055, 14'h0066, 1'b1);
    wait_lvl(6'h00);
    repeat (8) sync();
    chk({8'h00, level}, 14'h0000);
    $display("t_restart done");
  endtask
  task automatic t_align();
    src_u.send(14'h0123, 14'h0456, 1'b0);
    wait_lvl(6'h01);
    align = 1'b1;
    crise();
    crise();
    chk(code, 14'h0000);
    chk({8'h00, level}, 14'h0001);
    align = 1'b0;
    ticks = 0;
    unfs = 0;
    crise();
    chk(code, 14'h0123);
    repeat (3) crise();
    chk(ticks[13:0], 14'h0002);
    chk(unfs[13:0], 14'h0001);
    $display("t_align done");
  endtask
  task automatic t_over();
    for (int i = 0; i < 33; i++) src_u.send(14'h0100 + 14'(i), 14'h0200, 1'b0);
    wait_lvl(6'h20);
    repeat (3) sync();
    chk(ovfs[13:0], 14'h0001);
    crise();
    chk(code, 14'h0100);
    repeat (62) crise();
    chk(code, 14'h011f);
    crise();
    chk(code, 14'h0200);
    repeat (4) sync();
    chk({13'h0, empty}, 14'h0001);
    $display("t_over done");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    {nrst_i, cclk, align, gate, slp, rev} = 6'h00;
    repeat (3) @(posedge clk_i);
    #5;
    nrst_i = 1'b1;
    gate = 1'b1;
    t_pass();
    t_gate();
    t_sleep();
    t_restart();
    t_align();
    t_over();
    print_verdict();
  end
endmodule
bind lsife_top lsife_checker chk_u (.clk_i, .nrst_i, .input_word_clock_i,
  .fifo_restart_pair_i, .conversion_clock_i, .divider_align_pair_i, .transmit_gate_i,
  .sleep_i, .conv_code_o, .current_level_o, .channel_b_o, .divider_tick_o, .sleep_o,
  .fifo_level_o, .overflow_o, .underflow_o);
